// ===== dma_adv_model.sv
// Partner model of the DMA engine's pointer advance pulses.
// Assumes the bench holds a request bit for exactly one clock.
`timescale 1ns/1ps
`default_nettype none
module dma_adv_model (
    input wire logic clock_i,
    input wire logic [1:0] req_i,
    output logic read_adv_o = 1'b0,
    output logic write_adv_o = 1'b0
);
    // Launched off the falling edge, clear of the sampling edge
    always @(negedge clock_i) begin
        read_adv_o <= req_i[0];
        write_adv_o <= req_i[1];
    end
endmodule // dma_adv_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the free-queue pointer bank.
// Assumes the partner model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "tx_queue_map.vh"
module testbench;
    logic clock_i = 0, reset_i = 1, wr = 0, rd = 0;
    logic [9:0] addr = 0;
    logic [3:0] be_n = 0;
    logic [31:0] wd = 0;
    logic [1:0] req = 0;
    wire logic rv, ra, wa;
    wire logic [31:0] rdat, qb, sa, wpa, rpa, ea;
    int error_cnt = 0, check_count = 0, cycles = 0, seed = 66100, i, k;
    int m[6] = '{default: 0}; // hold, base, start, write, read, end
    tx_free_queue_pointer_regs u_tx_free_queue_pointer_regs (.clock_i, .reset_i,
        .reg_addr_i(addr), .reg_write_i(wr), .reg_read_i(rd), .byte_enable_lines_n_i(be_n),
        .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .free_write_ptr_adv_i(wa),
        .free_read_ptr_adv_i(ra), .queue_base_o(qb), .free_queue_start_addr_o(sa),
        .free_queue_write_ptr_addr_o(wpa), .free_queue_read_ptr_addr_o(rpa),
        .free_queue_end_addr_o(ea));
    dma_adv_model u_dma_adv_model (.clock_i, .req_i(req), .read_adv_o(ra), .write_adv_o(wa));
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) if (++cycles > 5000) begin
        error_cnt++;
        wrap_up;
    end
    task chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One access; a register index of 6 lands on an unmapped place
    task acc(bit w, int r, logic [31:0] d, logic [3:0] b);
        @(negedge clock_i);
        {wr, rd, addr, wd, be_n} <= {w, !w, 10'(`TXQ_OFS_BASE_LOW + 4 * r), d, b};
        @(negedge clock_i);
        {wr, rd} <= 2'b00;
        if (!w) chk("rvalid", b != `TXQ_BE_NONE, rv);
        if (!w && b != `TXQ_BE_NONE)
            chk("rdata", r == 1 ? m[1] >> 16 : r < 6 ? m[r] : 0, rdat);
        if (w && b != `TXQ_BE_NONE && r < 6) m[r] = r == 1 ? {d[15:0], m[0][15:0]} : d[15:0];
    endtask
    task outs;
        repeat (2) @(negedge clock_i);
        chk("base", m[1], qb);
        for (k = 2; k < 6; k++)
            chk("addr", m[1] + (m[k] << 2),
                k == 2 ? sa : k == 3 ? wpa : k == 4 ? rpa : ea);
    endtask
    task adv(int p);
        @(negedge clock_i);
        req <= p == 3 ? 2'b10 : 2'b01;
        @(negedge clock_i);
        req <= 2'b00;
        m[p] = (m[p] + 1) & 16'hFFFF;
        if (m[p] == m[5]) m[p] = m[2];
        outs;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clock_i);
        reset_i <= 0;
        for (i = 0; i < 7; i++) acc(0, i, 0, 0);
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            acc(1, 0, $random(seed) & 32'hFFFFFFFC, 0);
            outs;
            for (k = 1; k < 6; k++) acc(1, k, $random(seed), 4'({$random(seed)} % 15));
            outs;
            for (k = 0; k < 7; k++) acc(0, k, 0, 4'({$random(seed)} % 15));
        end
        $display("test random map done");
        acc(1, 2, 32'h0000FFFF, `TXQ_BE_NONE);
        acc(0, 2, 0, `TXQ_BE_NONE);
        acc(0, 2, 0, 0);
        foreach (m[j]) if (j > 1) acc(1, j, j == 5 ? 8 : 5, 0);
        for (i = 0; i < 4; i++) adv(4);
        for (i = 0; i < 4; i++) adv(3);
        acc(0, 4, 0, 0);
        // Host write and DMA advance hit the write pointer on one edge; the write wins
        @(negedge clock_i);
        req <= 2'b10;
        fork
            acc(1, 3, 2, 0);
            begin
                @(negedge clock_i);
                req <= 2'b00;
            end
        join
        outs;
        $display("test wrap done");
        wrap_up;
    end
endmodule // testbench
`default_nettype wire

// ===== tx_free_queue_pointer_regs.v
// Queue base and free-queue index registers for the transmit DMA logic.
// Assumes a register port on the core clock and a DMA engine that pulses advance requests.
`timescale 1ns/1ps
`default_nettype none
`include "tx_queue_map.vh"

module tx_free_queue_pointer_regs (
    // Clock and reset
    input wire clock_i,
    input wire reset_i,
    // Register port
    input wire [`TXQ_ADDR_W-1:0] reg_addr_i,
    input wire reg_write_i,
    input wire reg_read_i,
    input wire [3:0] byte_enable_lines_n_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // Pointer advance requests from the DMA engine
    input wire free_write_ptr_adv_i,
    input wire free_read_ptr_adv_i,
    // Physical addresses for the DMA engine
    output reg [`TXQ_BASE_W-1:0] queue_base_o,
    output reg [`TXQ_BASE_W-1:0] free_queue_start_addr_o,
    output reg [`TXQ_BASE_W-1:0] free_queue_write_ptr_addr_o,
    output reg [`TXQ_BASE_W-1:0] free_queue_read_ptr_addr_o,
    output reg [`TXQ_BASE_W-1:0] free_queue_end_addr_o
);

    reg [`TXQ_FIELD_W-1:0] base_hold_q;
    reg [`TXQ_BASE_W-1:0] queue_base_q;
    reg [`TXQ_FIELD_W-1:0] free_queue_start_q;
    reg [`TXQ_FIELD_W-1:0] free_queue_write_ptr_q;
    reg [`TXQ_FIELD_W-1:0] free_queue_read_ptr_q;
    reg [`TXQ_FIELD_W-1:0] free_queue_end_q;
    reg [`TXQ_FIELD_W-1:0] write_ptr_d;
    reg [`TXQ_FIELD_W-1:0] read_ptr_d;
    reg [31:0] rdata_d;
    wire access_ok;
    wire wr_en;
    wire [`TXQ_FIELD_W-1:0] wfield;

    // Access strobes after byte-enable qualification
    wire rd_en;
    wire wr_base_low;
    wire wr_base_high;
    wire wr_start;
    wire wr_write;
    wire wr_read;
    wire wr_end;

    // Index covers address bits 17:2, so the sum spans the full base width
    function [`TXQ_BASE_W-1:0] elem_addr;
        input [`TXQ_BASE_W-1:0] base;
        input [`TXQ_FIELD_W-1:0] idx;
        begin
            // Index lands on address bits 17:2
            elem_addr = {{(`TXQ_BASE_W-`TXQ_FIELD_W){1'b0}}, idx} << `TXQ_IDX_SHIFT;
            elem_addr = base + elem_addr;
        end
    endfunction

    // Step a pointer, folding back to start when it would land on end
    function [`TXQ_FIELD_W-1:0] step_ptr;
        input [`TXQ_FIELD_W-1:0] ptr;
        input [`TXQ_FIELD_W-1:0] start;
        input [`TXQ_FIELD_W-1:0] stop;
        reg [`TXQ_FIELD_W-1:0] nxt;
        begin
            nxt = ptr + 16'h0001;
            step_ptr = (nxt == stop) ? start : nxt;
        end
    endfunction

    // One offset compare, shared by every write strobe
    function reg_hit;
        input [`TXQ_ADDR_W-1:0] addr;
        input [`TXQ_ADDR_W-1:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    assign access_ok = (byte_enable_lines_n_i != `TXQ_BE_NONE);
    assign wr_en = reg_write_i && access_ok;
    // Upper half of write data is dropped on purpose
    assign wfield = reg_wdata_i[`TXQ_FIELD_W-1:0];
    // A read with every byte lane off is no access at all
    assign rd_en = reg_read_i && access_ok;

    // Write strobes, one per mapped offset; unmapped writes fall through
    assign wr_base_low = wr_en && reg_hit(reg_addr_i, `TXQ_OFS_BASE_LOW);
    assign wr_base_high = wr_en && reg_hit(reg_addr_i, `TXQ_OFS_BASE_HIGH);
    assign wr_start = wr_en && reg_hit(reg_addr_i, `TXQ_OFS_FREE_START);
    assign wr_write = wr_en && reg_hit(reg_addr_i, `TXQ_OFS_FREE_WRITE);
    assign wr_read = wr_en && reg_hit(reg_addr_i, `TXQ_OFS_FREE_READ);
    assign wr_end = wr_en && reg_hit(reg_addr_i, `TXQ_OFS_FREE_END);

    // Host write beats a same-cycle advance so software setup is never lost
    always @* begin
        write_ptr_d = free_queue_write_ptr_q;
        read_ptr_d = free_queue_read_ptr_q;
        if (wr_write) begin
            write_ptr_d = wfield;
        end else if (free_write_ptr_adv_i) begin
            write_ptr_d = step_ptr(free_queue_write_ptr_q, free_queue_start_q,
                free_queue_end_q);
        end
        if (wr_read) begin
            read_ptr_d = wfield;
        end else if (free_read_ptr_adv_i) begin
            read_ptr_d = step_ptr(free_queue_read_ptr_q, free_queue_start_q,
                free_queue_end_q);
        end
    end

    // Undefined upper bits and unmapped offsets read as zero
    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr_i)
            `TXQ_OFS_BASE_LOW: rdata_d = {16'h0000, base_hold_q};
            `TXQ_OFS_BASE_HIGH: rdata_d = {16'h0000, queue_base_q[31:16]};
            `TXQ_OFS_FREE_START: rdata_d = {16'h0000, free_queue_start_q};
            `TXQ_OFS_FREE_WRITE: rdata_d = {16'h0000, free_queue_write_ptr_q};
            `TXQ_OFS_FREE_READ: rdata_d = {16'h0000, free_queue_read_ptr_q};
            `TXQ_OFS_FREE_END: rdata_d = {16'h0000, free_queue_end_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Base pair; a high write without a fresh low write reuses the old hold
    always @(posedge clock_i) begin
        if (reset_i) begin
            base_hold_q <= `TXQ_FIELD_RESET;
            queue_base_q <= `TXQ_BASE_RESET;
        end else begin
            if (wr_base_low) begin
                base_hold_q <= wfield;
            end
            if (wr_base_high) begin
                queue_base_q <= {wfield, base_hold_q};
            end
        end
    end

    // Queue bounds move only under host control
    // End is an exclusive bound: a pointer stepping onto it wraps to start
    always @(posedge clock_i) begin
        if (reset_i) begin
            free_queue_start_q <= `TXQ_FIELD_RESET;
            free_queue_end_q <= `TXQ_FIELD_RESET;
        end else begin
            if (wr_start) begin
                free_queue_start_q <= wfield;
            end
            if (wr_end) begin
                free_queue_end_q <= wfield;
            end
        end
    end

    // Pointers follow host writes or DMA advances
    // Start above end is not guarded; keeping them ordered is the host's duty
    always @(posedge clock_i) begin
        if (reset_i) begin
            free_queue_write_ptr_q <= `TXQ_FIELD_RESET;
            free_queue_read_ptr_q <= `TXQ_FIELD_RESET;
        end else begin
            free_queue_write_ptr_q <= write_ptr_d;
            free_queue_read_ptr_q <= read_ptr_d;
        end
    end

    // Read data holds until the next accepted read
    always @(posedge clock_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h00000000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= rd_en;
            if (rd_en) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

    // Addresses lag the stored values by one cycle; the adders
    // stay off the output path at the cost of that lag
    always @(posedge clock_i) begin
        if (reset_i) begin
            queue_base_o <= `TXQ_BASE_RESET;
            free_queue_start_addr_o <= `TXQ_BASE_RESET;
            free_queue_write_ptr_addr_o <= `TXQ_BASE_RESET;
            free_queue_read_ptr_addr_o <= `TXQ_BASE_RESET;
            free_queue_end_addr_o <= `TXQ_BASE_RESET;
        end else begin
            queue_base_o <= queue_base_q;
            free_queue_start_addr_o <= elem_addr(queue_base_q, free_queue_start_q);
            free_queue_write_ptr_addr_o <= elem_addr(queue_base_q, free_queue_write_ptr_q);
            free_queue_read_ptr_addr_o <= elem_addr(queue_base_q, free_queue_read_ptr_q);
            free_queue_end_addr_o <= elem_addr(queue_base_q, free_queue_end_q);
        end
    end

endmodule // tx_free_queue_pointer_regs

`default_nettype wire

// ===== tx_queue_map.vh
// Register map of the transmit free-queue pointer bank.
// Included by the bank's design file; definitions only.
`ifndef TX_QUEUE_MAP_VH
`define TX_QUEUE_MAP_VH

`define TXQ_ADDR_W 10
`define TXQ_FIELD_W 16
`define TXQ_BASE_W 32

`define TXQ_OFS_BASE_LOW 10'h310
`define TXQ_OFS_BASE_HIGH 10'h314
`define TXQ_OFS_FREE_START 10'h318
`define TXQ_OFS_FREE_WRITE 10'h31C
`define TXQ_OFS_FREE_READ 10'h320
`define TXQ_OFS_FREE_END 10'h324

`define TXQ_FIELD_RESET 16'h0000
`define TXQ_BASE_RESET 32'h00000000
`define TXQ_IDX_SHIFT 2
`define TXQ_BE_NONE 4'hF

`endif

// ===== txq_regs_asserts.sv
// Port assertions for the free-queue pointer bank.
// Bound to the design top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "tx_queue_map.vh"
module txq_regs_asserts (
    // Every port of the bank, seen as inputs
    input wire logic clock_i, reset_i, reg_write_i, reg_read_i, reg_rvalid_o,
    input wire logic free_write_ptr_adv_i, free_read_ptr_adv_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic [3:0] byte_enable_lines_n_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o, queue_base_o, free_queue_start_addr_o,
    input wire logic [31:0] free_queue_write_ptr_addr_o, free_queue_read_ptr_addr_o,
    input wire logic [31:0] free_queue_end_addr_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    wire logic wr = reg_write_i && byte_enable_lines_n_i != `TXQ_BE_NONE;
    wire logic rd = reg_read_i && byte_enable_lines_n_i != `TXQ_BE_NONE;
    wire logic [31:0] wi = {14'h0, reg_wdata_i[15:0], 2'b00};
    wire logic hi_wr = wr && reg_addr_i == `TXQ_OFS_BASE_HIGH;
    wire logic [15:0] wlo = reg_wdata_i[15:0];
    // No host write and no read advance, so the read pointer, bounds and base stay put
    sequence quiet; !reg_write_i && !free_read_ptr_adv_i; endsequence
    rvalid_a: assert property (rd |=> reg_rvalid_o) else $error("read lost");
    no_access_a: assert property (!rd |=> !reg_rvalid_o) else $error("stray answer");
    upper_zero_a: assert property (reg_rvalid_o |-> reg_rdata_o[31:16] == 16'h0000)
        else $error("upper bits");
    base_hold_a: assert property ($changed(queue_base_o) |->
        $past(hi_wr, 2)) else $error("base moved");
    base_commit_a: assert property (hi_wr |->
        ##2 queue_base_o[31:16] == $past(wlo, 2)) else $error("base commit");
    start_addr_a: assert property ((wr && reg_addr_i == `TXQ_OFS_FREE_START) ##1 quiet |=>
        free_queue_start_addr_o == queue_base_o + $past(wi, 2)) else $error("start addr");
    end_addr_a: assert property ((wr && reg_addr_i == `TXQ_OFS_FREE_END) ##1 quiet |=>
        free_queue_end_addr_o == queue_base_o + $past(wi, 2)) else $error("end addr");
    read_adv_a: assert property (quiet ##1 (free_read_ptr_adv_i && !reg_write_i)
        ##1 quiet |=>
        free_queue_read_ptr_addr_o == $past(free_queue_read_ptr_addr_o, 2) + 32'h4 ||
        free_queue_read_ptr_addr_o == free_queue_start_addr_o) else $error("read advance");
endmodule // txq_regs_asserts
bind tx_free_queue_pointer_regs txq_regs_asserts u_txq_regs_asserts (.clock_i, .reset_i,
    .reg_write_i, .reg_read_i, .reg_rvalid_o, .free_write_ptr_adv_i, .free_read_ptr_adv_i,
    .reg_addr_i, .byte_enable_lines_n_i, .reg_wdata_i, .reg_rdata_o, .queue_base_o,
    .free_queue_start_addr_o, .free_queue_write_ptr_addr_o, .free_queue_read_ptr_addr_o,
    .free_queue_end_addr_o);
`default_nettype wire
